// ==== hw/sram_port_consts.svh ====
// Sizes and timing constants for the pipelined burst memory port
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH

`define SRAM_ADDR_W 20
`define SRAM_WORDS 1048576
`define SRAM_DATA_W 18
`define SRAM_LANES 2
`define SRAM_LANE_W 9
`define SRAM_BURST_BITS 2
`define SRAM_CLK_PERIOD_NS 10
`define SRAM_DESEL_HOLD_CYCLES 2
`define SRAM_BURST_RESET 2'h0
`define SRAM_DATA_RESET 18'h0_0000

`endif

// ==== hw/sram_port_pkg.sv ====
// Types shared by the memory port modules
package sram_port_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_DESEL = 4'b1000
  } port_state_t;

endpackage

// ==== hw/burst_counter.sv ====
// Two-bit burst sequencer, linear or interleaved order
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_consts.svh"

module burst_counter #(
  parameter int BITS = `SRAM_BURST_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic advance,
  input wire logic linear,
  input wire logic [BITS-1:0] base_in,
  // Burst address low bits
  output logic [BITS-1:0] cur_lo,
  output logic [BITS-1:0] nxt_lo
);

  logic [BITS-1:0] base_ff;
  logic [BITS-1:0] cnt_ff;
  logic [BITS-1:0] nxt_cnt;

  assign nxt_cnt = cnt_ff + 1'b1;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_ff <= '0;
      cnt_ff <= '0;
    end
    else if (load)
    begin
      base_ff <= base_in;
      cnt_ff <= '0;
    end
    else if (advance)
    begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Wraps inside the aligned group; upper bits never change
  assign cur_lo = linear ? (base_ff + cnt_ff) : (base_ff ^ cnt_ff);
  assign nxt_lo = linear ? (base_ff + nxt_cnt) : (base_ff ^ nxt_cnt);

endmodule
`default_nettype wire

// ==== hw/word_store.sv ====
// Flip-flop word array with per-lane write strobes
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_consts.svh"

module word_store #(
  parameter int AW = `SRAM_ADDR_W,
  parameter int LANES = `SRAM_LANES,
  parameter int LW = `SRAM_LANE_W
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic [LANES-1:0] wr_lane,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [LANES*LW-1:0] wr_data,
  // Read side
  input wire logic [AW-1:0] rd_addr,
  output logic [LANES*LW-1:0] rd_data
);

  // No reset: contents are undefined at power up, as in a real array
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : lane
      logic [LW-1:0] mem [0:(1<<AW)-1];
      always_ff @(posedge clk)
      begin
        if (wr_lane[g])
        begin
          mem[wr_addr] <= wr_data[g*LW +: LW];
        end
      end
      assign rd_data[g*LW +: LW] = mem[rd_addr];
    end
  endgenerate

endmodule
`default_nettype wire

// ==== hw/pipelined_burst_sync_sram_port.sv ====
// Pipelined burst synchronous memory: bus front end, burst logic, array
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_consts.svh"

module pipelined_burst_sync_sram_port #(
  parameter int AW = `SRAM_ADDR_W,
  parameter int LANES = `SRAM_LANES,
  parameter int LW = `SRAM_LANE_W,
  parameter int BB = `SRAM_BURST_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Address and strobes
  input wire logic [AW-1:0] addr,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_advance_n,
  // Chip enables
  input wire logic master_select_n,
  input wire logic select_high,
  input wire logic select_low_n,
  // Write enables
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [LANES-1:0] lane_write_bus_n,
  // Asynchronous and static controls
  input wire logic out_enable_n,
  input wire logic burst_order_sel_n,
  // Data pins, split three ways
  input wire logic [LANES*LW-1:0] dq_in,
  output logic [LANES*LW-1:0] dq_out,
  output logic dq_oe
);

  localparam int DW = LANES * LW;

  // Two-flop synchronisers for the asynchronous and static pins
  logic oe_meta_ff;
  logic oe_sync_ff;
  logic order_meta_ff;
  logic order_sync_ff;

  // Pipeline state
  sram_port_pkg::port_state_t state_ff;
  sram_port_pkg::port_state_t nxt_state;
  logic [AW-BB-1:0] addr_hi_ff;
  logic [DW-1:0] dout_ff;
  logic out_valid_ff;
  logic lane_low_ff;

  // Pending write, committed one edge after capture
  logic wr_pend_ff;
  logic [LANES-1:0] wr_lane_ff;
  logic [AW-1:0] wr_addr_ff;
  logic [DW-1:0] din_ff;

  // Decode
  logic sel_all;
  logic proc_start;
  logic proc_blocked;
  logic ctrl_start;
  logic both_high;
  logic selected;
  logic [LANES-1:0] lane_en;
  logic is_write;
  logic do_load;
  logic do_advance;
  logic do_write;
  logic [AW-1:0] wr_target;
  logic [LANES-1:0] wr_lanes;

  // Burst and array
  logic [BB-1:0] cur_lo;
  logic [BB-1:0] nxt_lo;
  logic [AW-1:0] cur_addr;
  logic [DW-1:0] rd_word;
  logic [DW-1:0] fwd_word;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oe_meta_ff <= 1'b1;
      oe_sync_ff <= 1'b1;
      order_meta_ff <= 1'b1;
      order_sync_ff <= 1'b1;
    end
    else
    begin
      oe_meta_ff <= out_enable_n;
      oe_sync_ff <= oe_meta_ff;
      order_meta_ff <= burst_order_sel_n;
      order_sync_ff <= order_meta_ff;
    end
  end

  // Chip enable polarities
  assign sel_all = !master_select_n && select_high && !select_low_n;

  // Processor strobe needs the master enable; controller strobe does not
  assign proc_start = !processor_addr_strobe_n && !master_select_n;
  assign proc_blocked = !processor_addr_strobe_n && master_select_n;
  // Controller strobe counts only with processor strobe high
  assign ctrl_start = !controller_addr_strobe_n && processor_addr_strobe_n;
  assign both_high = processor_addr_strobe_n && controller_addr_strobe_n;
  assign selected = (state_ff == sram_port_pkg::ST_READ) ||
                    (state_ff == sram_port_pkg::ST_WRITE);

  // Write lane decode
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : lane_dec
      // Global write overrides lanes; else lane plus byte write enable
      assign lane_en[g] = !global_write_n ||
                          (!byte_write_enable_n && !lane_write_bus_n[g]);
    end
  endgenerate

  // No active lane is a read
  assign is_write = |lane_en;

  // Cycle decode, processor strobe first
  always_comb
  begin
    nxt_state = state_ff;
    do_load = 1'b0;
    do_advance = 1'b0;
    do_write = 1'b0;
    wr_target = cur_addr;
    wr_lanes = '0;
    if (proc_start)
    begin
      // Write enables and advance are not looked at on this edge
      if (sel_all)
      begin
        do_load = 1'b1;
        nxt_state = sram_port_pkg::ST_READ;
      end
      else if (state_ff == sram_port_pkg::ST_READ)
      begin
        nxt_state = sram_port_pkg::ST_DESEL;
      end
      else
      begin
        nxt_state = sram_port_pkg::ST_IDLE;
      end
    end
    else if (ctrl_start)
    begin
      if (sel_all)
      begin
        do_load = 1'b1;
        // Write enables sampled on the starting edge
        if (is_write)
        begin
          do_write = 1'b1;
          wr_target = addr;
          wr_lanes = lane_en;
          nxt_state = sram_port_pkg::ST_WRITE;
        end
        else
        begin
          nxt_state = sram_port_pkg::ST_READ;
        end
      end
      else if (state_ff == sram_port_pkg::ST_READ)
      begin
        nxt_state = sram_port_pkg::ST_DESEL;
      end
      else
      begin
        nxt_state = sram_port_pkg::ST_IDLE;
      end
    end
    else if (both_high && selected)
    begin
      // Continue cycle: advance after the strobe edge
      do_advance = !burst_advance_n;
      if (is_write)
      begin
        do_write = 1'b1;
        wr_target = {addr_hi_ff, (do_advance ? nxt_lo : cur_lo)};
        wr_lanes = lane_en;
        nxt_state = sram_port_pkg::ST_WRITE;
      end
      else
      begin
        nxt_state = sram_port_pkg::ST_READ;
      end
    end
    else if (state_ff == sram_port_pkg::ST_DESEL)
    begin
      nxt_state = sram_port_pkg::ST_IDLE;
    end
    else if (proc_blocked)
    begin
      // Blocked strobe: hold everything for this edge
      nxt_state = state_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= sram_port_pkg::ST_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_hi_ff <= '0;
    end
    else if (do_load)
    begin
      addr_hi_ff <= addr[AW-1:BB];
    end
  end

  // Order pin high or floating means interleaved
  burst_counter #(
    .BITS(BB)
  ) u_burst (
    .clk(clk),
    .rst_n(rst_n),
    .load(do_load),
    .advance(do_advance),
    .linear(!order_sync_ff),
    .base_in(addr[BB-1:0]),
    .cur_lo(cur_lo),
    .nxt_lo(nxt_lo)
  );

  assign cur_addr = {addr_hi_ff, cur_lo};

  // Input data register and deferred commit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_ff <= 1'b0;
      wr_lane_ff <= '0;
      wr_addr_ff <= '0;
      din_ff <= `SRAM_DATA_RESET;
    end
    else
    begin
      wr_pend_ff <= do_write;
      wr_lane_ff <= wr_lanes;
      if (do_write)
      begin
        din_ff <= dq_in;
        wr_addr_ff <= wr_target;
      end
    end
  end

  word_store #(
    .AW(AW),
    .LANES(LANES),
    .LW(LW)
  ) u_store (
    .clk(clk),
    .wr_lane(wr_pend_ff ? wr_lane_ff : {LANES{1'b0}}),
    .wr_addr(wr_addr_ff),
    .wr_data(din_ff),
    .rd_addr(cur_addr),
    .rd_data(rd_word)
  );

  // Forward a write still waiting in the input register
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : fwd
      assign fwd_word[g*LW +: LW] =
        (wr_pend_ff && wr_lane_ff[g] && (wr_addr_ff == cur_addr)) ?
        din_ff[g*LW +: LW] : rd_word[g*LW +: LW];
    end
  endgenerate

  // Output register loads one edge after the address register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dout_ff <= `SRAM_DATA_RESET;
    end
    else if (state_ff == sram_port_pkg::ST_READ)
    begin
      dout_ff <= fwd_word;
    end
  end

  // Read data stays valid through the deselect state: two cycles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_valid_ff <= 1'b0;
    end
    else
    begin
      out_valid_ff <= (state_ff == sram_port_pkg::ST_READ) ||
                      (state_ff == sram_port_pkg::ST_DESEL);
    end
  end

  // Lane writes seen low cut the drivers; ignored on processor strobe edge
  // Any write edge cuts them too, so a slow output enable cannot drive a write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lane_low_ff <= 1'b0;
    end
    else
    begin
      lane_low_ff <= (!proc_start && !(&lane_write_bus_n)) || do_write;
    end
  end

  // Output enable passes two flops, so it acts two edges late
  assign dq_oe = out_valid_ff && !oe_sync_ff && !lane_low_ff;
  assign dq_out = dout_ff;

endmodule
`default_nettype wire

// ==== bench/sram_port_props.sv ====
// Bus protocol assertions for the burst memory port
`timescale 1ns/1ps
`default_nettype none

module sram_port_props #(
  parameter int LANES = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus controls
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic master_select_n,
  input wire logic select_high,
  input wire logic select_low_n,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [LANES-1:0] lane_write_bus_n,
  input wire logic out_enable_n,
  // Drive enable
  input wire logic dq_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic on_sel;
  logic no_wr;
  logic quiet;
  logic desel_c;
  assign on_sel = select_high && !select_low_n;
  assign no_wr = global_write_n && (&lane_write_bus_n || byte_write_enable_n);
  // Read continue with output enable held, so nothing else can switch drivers
  // Lanes stay high: a low lane cuts the drivers even in a read
  assign quiet = processor_addr_strobe_n && controller_addr_strobe_n && !out_enable_n &&
                 global_write_n && (&lane_write_bus_n);
  // Controller strobe deselect with output enable held and lanes idle
  assign desel_c = processor_addr_strobe_n && !controller_addr_strobe_n && !on_sel &&
                   !out_enable_n && (&lane_write_bus_n);

  property p_lane_off;
    processor_addr_strobe_n && !byte_write_enable_n && !(&lane_write_bus_n) |=> !dq_oe;
  endproperty
  a_lane_off: assert property (p_lane_off) else $error("drivers on after lane write");

  property p_oe_off;
    out_enable_n [*3] |-> !dq_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("drivers on with enable off");

  property p_oe_rise;
    $rose(dq_oe) |-> !$past(out_enable_n, 2);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive began without enable");

  property p_read_drive;
    !out_enable_n [*2] ##0 (!processor_addr_strobe_n && !master_select_n && on_sel)
      ##1 quiet [*2] |=> dq_oe;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read start not driven");

  property p_ctrl_read;
    !out_enable_n [*2] ##0 (processor_addr_strobe_n && !controller_addr_strobe_n
      && !master_select_n && on_sel && no_wr) ##1 quiet [*2] |=> dq_oe;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("lane-free cycle not read");

  property p_ctrl_wr;
    processor_addr_strobe_n && !controller_addr_strobe_n && !master_select_n && on_sel
      && !global_write_n |=> !dq_oe;
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("drivers on in write start");

  // Two quiet edges first, so the deselect really ends a running read
  property p_dcd_hold;
    quiet [*2] ##1 (desel_c && dq_oe) ##1 quiet |-> dq_oe ##1 dq_oe;
  endproperty
  a_dcd_hold: assert property (p_dcd_hold) else $error("deselect dropped too soon");

  property p_dcd_drop;
    quiet [*2] ##1 (desel_c && dq_oe) ##1 quiet [*2] |=> !dq_oe;
  endproperty
  a_dcd_drop: assert property (p_dcd_drop) else $error("deselect held too long");
endmodule

bind pipelined_burst_sync_sram_port sram_port_props #(.LANES(LANES)) props_u (.clk, .rst_n,
  .processor_addr_strobe_n, .controller_addr_strobe_n, .master_select_n, .select_high,
  .select_low_n, .global_write_n, .byte_write_enable_n, .lane_write_bus_n, .out_enable_n,
  .dq_oe);

`default_nettype wire

// ==== bench/bus_master_model.sv ====
// Bus master model driving the burst memory port
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_consts.svh"

module bus_master_model (
  // Clock
  input wire logic clk,
  // Address and strobes
  output logic [`SRAM_ADDR_W-1:0] addr,
  output logic processor_addr_strobe_n,
  output logic controller_addr_strobe_n,
  output logic burst_advance_n,
  // Chip enables
  output logic master_select_n,
  output logic select_high,
  output logic select_low_n,
  // Write enables
  output logic global_write_n,
  output logic byte_write_enable_n,
  output logic [1:0] lane_write_bus_n,
  // Static controls and data
  output logic out_enable_n,
  output logic burst_order_sel_n,
  output logic [`SRAM_DATA_W-1:0] dq_in
);
  initial
  begin
    addr = 20'h0_0000;
    processor_addr_strobe_n = 1'b1;
    controller_addr_strobe_n = 1'b1;
    burst_advance_n = 1'b1;
    master_select_n = 1'b0;
    select_high = 1'b1;
    select_low_n = 1'b0;
    global_write_n = 1'b1;
    byte_write_enable_n = 1'b1;
    lane_write_bus_n = 2'h3;
    out_enable_n = 1'b1;
    burst_order_sel_n = 1'b1;
    dq_in = 18'h0_0000;
  end

  // Ctl bits: deselect, proc strobe, ctrl strobe, advance, global, byte enable
  task automatic cyc(input logic [5:0] ctl, input logic [1:0] ln, input logic [19:0] a,
    input logic [17:0] d);
    @(posedge clk);
    select_high <= !ctl[5];
    processor_addr_strobe_n <= ctl[4];
    controller_addr_strobe_n <= ctl[3];
    burst_advance_n <= ctl[2];
    global_write_n <= ctl[1];
    byte_write_enable_n <= ctl[0];
    lane_write_bus_n <= ln;
    addr <= a;
    // Idle data lines toggle so a stale word can never pass as written
    dq_in <= (!ctl[1] || (!ctl[0] && !(&ln))) ? d : ~dq_in;
  endtask
endmodule

`default_nettype wire

// ==== bench/pipelined_burst_sync_sram_port_bench.sv ====
// Self-checking bench for the burst memory port
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_consts.svh"

module pipelined_burst_sync_sram_port_bench;
  localparam logic [5:0] RDP = 6'h0B;
  localparam logic [5:0] CSB = 6'h16;
  localparam logic [5:0] WRG = 6'h15;
  localparam logic [5:0] CWA = 6'h19;
  localparam logic [5:0] CRA = 6'h1B;
  localparam logic [5:0] IDL = 6'h1F;
  localparam logic [5:0] DES = 6'h37;
  localparam logic [19:0] A0 = 20'h0_1230;
  localparam logic [19:0] A1 = 20'h0_1231;
  localparam logic [19:0] A2 = 20'h0_1232;
  localparam logic [17:0] D0 = 18'h1_2345;
  localparam logic [17:0] D1 = 18'h2_ABCD;
  localparam logic [17:0] D2 = 18'h3_0F0F;
  localparam logic [17:0] D3 = 18'h0_5A5A;
  localparam logic [17:0] W0 = {D3[17:9], 9'h1FF};

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [19:0] addr;
  logic processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
  logic master_select_n, select_high, select_low_n;
  logic global_write_n, byte_write_enable_n, out_enable_n, burst_order_sel_n;
  logic [1:0] lane_write_bus_n;
  logic [17:0] dq_in, dq_out;
  logic dq_oe;
  int num_errors = 0;
  int checks = 0;

  always #5 clk = ~clk;

  pipelined_burst_sync_sram_port dut_u (.clk, .rst_n, .addr, .processor_addr_strobe_n,
    .controller_addr_strobe_n, .burst_advance_n, .master_select_n, .select_high,
    .select_low_n, .global_write_n, .byte_write_enable_n, .lane_write_bus_n, .out_enable_n,
    .burst_order_sel_n, .dq_in, .dq_out, .dq_oe);

  bus_master_model master_u (.clk, .addr, .processor_addr_strobe_n, .controller_addr_strobe_n,
    .burst_advance_n, .master_select_n, .select_high, .select_low_n, .global_write_n,
    .byte_write_enable_n, .lane_write_bus_n, .out_enable_n, .burst_order_sel_n, .dq_in);

  task check(input logic [17:0] seen, input logic [17:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task idle(input int n);
    repeat (n) master_u.cyc(IDL, 2'h3, 20'h0_0000, 18'h0_0000);
  endtask

  task test_wr;
    logic [17:0] wd [4];
    wd = '{D0, D1, D2, D3};
    for (int k = 0; k < 4; k++)
      master_u.cyc(k == 0 ? WRG : CWA, 2'h3, A1, wd[k]);
    idle(2);
    $display("global write burst done");
  endtask

  task test_byte;
    master_u.cyc(CSB, 2'h2, A0, 18'h3_FFFF);
    idle(2);
    $display("lane write done");
  endtask

  // Four-beat read, then deselect; beats land one edge after each address
  task test_rd(input logic [5:0] start, input logic [19:0] base, input logic [71:0] exp);
    master_u.cyc(start, 2'h3, base, 18'h0_0000);
    for (int k = 1; k < 6; k++)
    begin
      master_u.cyc(k < 4 ? CRA : (k == 4 ? IDL : DES), 2'h3, base, 18'h0_0000);
      #1;
      if (k > 1)
        check(dq_out, exp[71 - 18 * (k - 2) -: 18]);
    end
    check({17'h0_0000, dq_oe}, 18'h0_0001);
    idle(3);
    $display("read burst from %h done", base);
  endtask

  // Blocked processor strobe must not reload or advance; controller strobe still deselects
  task test_block;
    master_u.cyc(RDP, 2'h3, A2, 18'h0_0000);
    master_u.cyc(RDP, 2'h3, A0, 18'h0_0000);
    master_u.master_select_n <= 1'b1;
    master_u.cyc(IDL, 2'h3, A0, 18'h0_0000);
    master_u.cyc(DES, 2'h3, A0, 18'h0_0000);
    #1;
    check(dq_out, D1);
    idle(2);
    #1;
    check({17'h0_0000, dq_oe}, 18'h0_0001);
    idle(1);
    #1;
    check({17'h0_0000, dq_oe}, 18'h0_0000);
    master_u.master_select_n <= 1'b0;
    $display("blocked strobe test done");
  endtask

  task results;
    $display("checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #20000;
    num_errors++;
    results();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    master_u.burst_order_sel_n <= 1'b0;
    idle(3);
    test_wr();
    test_byte();
    master_u.out_enable_n <= 1'b0;
    master_u.burst_order_sel_n <= 1'b1;
    idle(3);
    test_rd(RDP, A1, {D0, W0, D2, D1});
    master_u.burst_order_sel_n <= 1'b0;
    idle(3);
    test_rd(CSB, A2, {D1, D2, W0, D0});
    test_block();
    results();
  end
endmodule

`default_nettype wire
